// ===== tb/jcp_host.sv
`timescale 1ns/10ps
`default_nettype none
module jcp_host (
  input  wire logic i_tdo,
  input  wire logic i_oe_drive,
  input  wire logic i_init_drive,
  input  wire logic i_fpga_hold,
  input  wire logic i_fpga_done,
  output var logic  o_tck,
  output var logic  o_tms,
  output var logic  o_tdi,
  output logic      o_oe_line,
  output logic      o_cs_n,
  output logic      o_reconfig_n
);
  // pulled-up open-drain wires
  assign o_oe_line = !(i_oe_drive || i_fpga_hold);
  assign o_cs_n = i_fpga_done;
  // fpga floats its flash port while held in reconfig
  assign o_reconfig_n = !i_init_drive;
  // tck rests low outside frames
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  task automatic step(input logic tms, input logic tdi,
                      output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #62.5;
    tdo = i_tdo;
    o_tck = 1'b1;
    #62.5;
    o_tck = 1'b0;
  endtask
  // tdi toggles when it carries no data
  task automatic ctl(input logic tms);
    logic b;
    step(tms, ~o_tdi, b);
  endtask
  task automatic tap_reset;
    repeat (5) ctl(1'b1);
    ctl(1'b0);
  endtask
  task automatic scan(input logic ir, input int n,
                      input logic [207:0] din,
                      output logic [207:0] dout);
    ctl(1'b1);
    if (ir) ctl(1'b1);
    ctl(1'b0);
    ctl(1'b0);
    for (int k = 0; k < n; k++) step(k == n - 1, din[k], dout[k]);
    ctl(1'b1);
    ctl(1'b0);
  endtask
endmodule
`default_nettype wire

// ===== tb/jcp_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module jcp_port_bench;
  import jcp_pkg::*;
  localparam int POR_S = 20;
  localparam int POR_L = 50;
  logic i_clk, i_rst, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe;
  logic i_por_delay_select, i_oe_line, o_oe_line, o_oe_line_oe;
  logic i_chip_select_sense_n, o_config_init_pin_n, o_config_init_pin_oe;
  logic o_extest_active, o_config_enable, o_config_idle;
  logic hold, done, reconf_n;
  logic [BSR_LEN-1:0] i_pin_levels, o_pin_drive;
  logic [ID_LEN-1:0]  i_usercode;
  int checked, bad_count, cyc;
  jcp_port #(.POR_SHORT(POR_S), .POR_LONG(POR_L)) jcp_port_i (
    .i_clk                 (i_clk),
    .i_rst                 (i_rst),
    .i_tck                 (i_tck),
    .i_tms                 (i_tms),
    .i_tdi                 (i_tdi),
    .o_tdo                 (o_tdo),
    .o_tdo_oe              (o_tdo_oe),
    .i_por_delay_select    (i_por_delay_select),
    .i_oe_line             (i_oe_line),
    .o_oe_line             (o_oe_line),
    .o_oe_line_oe          (o_oe_line_oe),
    .i_chip_select_sense_n (i_chip_select_sense_n),
    .o_config_init_pin_n   (o_config_init_pin_n),
    .o_config_init_pin_oe  (o_config_init_pin_oe),
    .i_pin_levels          (i_pin_levels),
    .o_pin_drive           (o_pin_drive),
    .o_extest_active       (o_extest_active),
    .i_usercode            (i_usercode),
    .o_config_enable       (o_config_enable),
    .o_config_idle         (o_config_idle)
  );
  jcp_host jcp_host_i (.i_tdo(o_tdo), .i_oe_drive(o_oe_line_oe),
    .i_init_drive(o_config_init_pin_oe), .i_fpga_hold(hold),
    .i_fpga_done(done), .o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi),
    .o_oe_line(i_oe_line), .o_cs_n(i_chip_select_sense_n),
    .o_reconfig_n(reconf_n));
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      end_sim;
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic power(input logic s, input logic d, input logic h,
                       output int n);
    if ($time > 0) @(negedge i_clk);
    i_rst = 1'b1;
    i_por_delay_select = s;
    done = d;
    hold = h;
    repeat (20) @(negedge i_clk);
    i_rst = 1'b0;
    n = 0;
    while (o_oe_line_oe === 1'b1 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
  endtask
  task automatic leave(input logic exp_oe);
    jcp_host_i.ctl(1'b1);
    `CHK(o_config_init_pin_oe, exp_oe)
    for (int k = 0; k < 4; k++) jcp_host_i.ctl(k == 1 || k == 2);
  endtask
  initial begin
    logic [207:0] d, din;
    int n;
    logic [9:0] op [6];
    int len [6];
    logic [31:0] ex [6];
    i_clk = 1'b0;
    i_pin_levels = 174'({6{32'h5a0f_c3e1}});
    i_usercode = 32'h1234_abcd;
    din = 208'({7{32'hc3a5_0f96}});
    power(1'b0, 1'b0, 1'b1, n);
    `CHK(n inside {[POR_L - 1:POR_L + 4]}, 1'b1)
    repeat (8) @(negedge i_clk);
    `CHK(o_config_enable, 1'b0)
    hold = 1'b0;
    repeat (8) @(negedge i_clk);
    `CHK(o_config_enable, 1'b1)
    power(1'b1, 1'b1, 1'b0, n);
    repeat (8) @(negedge i_clk);
    `CHK(o_config_idle, 1'b1)
    done = 1'b0;
    hold = 1'b1;
    repeat (8) @(negedge i_clk);
    hold = 1'b0;
    jcp_host_i.tap_reset;
    jcp_host_i.scan(1'b1, IR_LEN, 208'(OP_START_CFG), d);
    `CHK(o_config_idle, 1'b1)
    `CHK(o_config_enable, 1'b0)
    power(1'b1, 1'b0, 1'b0, n);
    `CHK(n inside {[POR_S - 1:POR_S + 4]}, 1'b1)
    repeat (8) @(negedge i_clk);
    `CHK(i_oe_line, 1'b1)
    `CHK(o_config_idle, 1'b0)
    `CHK(o_config_enable, 1'b1)
    `CHK(o_oe_line, 1'b0)
    hold = 1'b1;
    repeat (8) @(negedge i_clk);
    `CHK(o_config_enable, 1'b0)
    hold = 1'b0;
    repeat (8) @(negedge i_clk);
    `CHK(o_config_enable, 1'b1)
    `CHK(o_oe_line_oe, 1'b0)
    // test traffic only after the power sequence
    jcp_host_i.tap_reset;
    op = '{OP_IDCODE, OP_USERCODE, OP_BYPASS, 10'h2aa, OP_SAMPLE, OP_EXTEST};
    len = '{ID_LEN, ID_LEN, 1, 1, BSR_LEN, BSR_LEN};
    ex = '{ID_VALUE, i_usercode, {din[30:0], 1'b0}, {din[30:0], 1'b0},
           i_pin_levels[31:0], i_pin_levels[31:0]};
    for (int r = 0; r < 6; r++) begin
      jcp_host_i.scan(1'b1, IR_LEN, 208'(op[r]), d);
      `CHK(d[9:0], 10'h001)
      `CHK(o_tdo_oe, 1'b0)
      jcp_host_i.scan(1'b0, 206, din, d);
      `CHK(d[31:0], ex[r])
      `CHK(d[len[r] +: 32], din[31:0])
      `CHK(o_extest_active, op[r] == OP_EXTEST)
      if (op[r] == OP_SAMPLE) `CHK(o_pin_drive, din[205:32])
    end
    jcp_host_i.scan(1'b1, IR_LEN, 208'(OP_START_CFG), d);
    `CHK(reconf_n, 1'b0)
    `CHK(o_config_init_pin_n, 1'b0)
    leave(1'b0);
    `CHK(reconf_n, 1'b0)
    jcp_host_i.scan(1'b1, IR_LEN, 208'(10'h2aa), d);
    `CHK(o_config_init_pin_oe, 1'b0)
    jcp_host_i.scan(1'b1, IR_LEN, 208'(OP_HOLD_CFG), d);
    `CHK(o_config_init_pin_oe, 1'b1)
    `CHK(reconf_n, 1'b0)
    leave(1'b1);
    jcp_host_i.scan(1'b1, IR_LEN, 208'(10'h2aa), d);
    `CHK(o_config_init_pin_oe, 1'b1)
    jcp_host_i.scan(1'b1, IR_LEN, 208'(OP_START_CFG), d);
    leave(1'b0);
    end_sim;
  end
endmodule
`default_nettype wire

// ===== tb/jcp_sva.sv
`timescale 1ns/10ps
`default_nettype none
module jcp_sva #(
  parameter int POR_SHORT = 20,
  parameter int POR_LONG  = 50
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_oe_line,
  input wire logic i_chip_select_sense_n,
  input wire logic o_oe_line_oe,
  input wire logic o_tdo_oe,
  input wire logic o_config_init_pin_oe,
  input wire logic o_config_enable,
  input wire logic o_config_idle
);
  logic [15:0] cnt_r;
  always_ff @(posedge i_clk) begin
    if (i_rst)
      cnt_r <= 16'h0000;
    else if (cnt_r != 16'hffff)
      cnt_r <= cnt_r + 16'h0001;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_POR_MIN: assert property (
    $fell(o_oe_line_oe) |-> cnt_r >= POR_SHORT - 1)
    else $error("power-on delay too short");
  AST_POR_MAX: assert property (
    o_oe_line_oe |-> cnt_r <= POR_LONG + 4)
    else $error("power-on delay too long");
  AST_OE_FREE: assert property (
    $fell(o_oe_line_oe) |=> !o_oe_line_oe [*8])
    else $error("output-enable driven again");
  AST_CS_IDLE: assert property (
    $rose(i_oe_line) && !o_oe_line_oe && !o_config_enable
    && i_chip_select_sense_n |-> ##[1:5] o_config_idle)
    else $error("idle not entered");
  AST_CS_RUN: assert property (
    $rose(i_oe_line) && !o_oe_line_oe && !o_config_idle
    && !i_chip_select_sense_n |-> ##[1:5] o_config_enable)
    else $error("configuration not enabled");
  AST_IDLE_EXCL: assert property (
    o_config_idle |-> !o_config_enable)
    else $error("enable while idle");
  AST_IDLE_STICKY: assert property (
    o_config_idle |=> o_config_idle)
    else $error("idle left without power-up");
  AST_EXT_HOLD: assert property (
    !i_oe_line [*5] |-> !o_config_enable)
    else $error("enable while line held low");
  AST_INIT_IDLE: assert property (
    $rose(o_config_init_pin_oe) |-> !o_tdo_oe)
    else $error("init pin driven while shifting");
  cover property (o_config_idle);
  cover property ($rose(o_config_enable));
  cover property ($rose(o_config_init_pin_oe));
endmodule
bind jcp_port jcp_sva #(.POR_SHORT(POR_SHORT), .POR_LONG(POR_LONG))
  jcp_sva_i (
    .i_clk                 (i_clk),
    .i_rst                 (i_rst),
    .i_oe_line             (i_oe_line),
    .i_chip_select_sense_n (i_chip_select_sense_n),
    .o_oe_line_oe          (o_oe_line_oe),
    .o_tdo_oe              (o_tdo_oe),
    .o_config_init_pin_oe  (o_config_init_pin_oe),
    .o_config_enable       (o_config_enable),
    .o_config_idle         (o_config_idle)
  );
`default_nettype wire

// ===== verilog/jcp_pkg.sv
package jcp_pkg;
  localparam int          IR_LEN       = 10;
  localparam int          BSR_LEN      = 174;
  localparam int          ID_LEN       = 32;
  localparam logic [9:0]  OP_SAMPLE    = 10'h055;
  localparam logic [9:0]  OP_EXTEST    = 10'h000;
  localparam logic [9:0]  OP_BYPASS    = 10'h3ff;
  localparam logic [9:0]  OP_IDCODE    = 10'h059;
  localparam logic [9:0]  OP_USERCODE  = 10'h079;
  localparam logic [9:0]  OP_START_CFG = 10'h061;
  localparam logic [9:0]  OP_HOLD_CFG  = 10'h065;
  localparam logic [1:0]  IR_CAPTURE   = 2'h1;
  // identification value: arbitrary, not tied to any real part
  localparam logic [31:0] ID_VALUE     = 32'h0a5c3e01;
  localparam logic [31:0] USERCODE_DEF = 32'hffffffff;
  localparam int          CLK_MHZ      = 100;
  localparam int          POR_SHORT_MS = 2;
  localparam int          POR_LONG_MS  = 100;
  localparam int          POR_SHORT_CYC = POR_SHORT_MS * 1000 * CLK_MHZ;
  localparam int          POR_LONG_CYC  = POR_LONG_MS * 1000 * CLK_MHZ;
  localparam int          POR_CNT_W    = 24;

  typedef enum logic [3:0] {
    TAP_RESET   = 4'h0, TAP_IDLE    = 4'h1, TAP_SEL_DR  = 4'h2,
    TAP_CAP_DR  = 4'h3, TAP_SH_DR   = 4'h4, TAP_EX1_DR  = 4'h5,
    TAP_PAU_DR  = 4'h6, TAP_EX2_DR  = 4'h7, TAP_UPD_DR  = 4'h8,
    TAP_SEL_IR  = 4'h9, TAP_CAP_IR  = 4'ha, TAP_SH_IR   = 4'hb,
    TAP_EX1_IR  = 4'hc, TAP_PAU_IR  = 4'hd, TAP_EX2_IR  = 4'he,
    TAP_UPD_IR  = 4'hf
  } jcp_tap_type;

  typedef enum logic [1:0] {
    PWR_POR  = 2'h0,
    PWR_WAIT = 2'h1,
    PWR_RUN  = 2'h2,
    PWR_IDLE = 2'h3
  } jcp_pwr_type;
endpackage

// ===== verilog/jcp_port.sv
// Overview of operation
// R1: instruction register is ten bits; each opcode shift is ten bits long.
// R2: 174-cell boundary register sits between data in and out for scan opcodes.
// R3: sample/preload captures pins harmlessly and accepts a preload pattern.
// R4: extest drives outputs from boundary cells and captures input levels.
// R5: all-ones opcode routes data through a one-bit bypass register.
// R6: identification opcode shifts the fixed identification value out.
// R7: usercode opcode shifts a 32-bit user pattern out.
// R8: after start-config update, init pin goes low in run-test/idle.
// R9: init pin is released when the controller leaves run-test/idle.
// R10: hold opcode keeps init pin low during in-system programming.
// R11: after hold, init pin stays low until start-config is executed.
// R12: external master must float its flash interface before controller access.
// R13: when power-on delay ends, output-enable line is released.
// R14: delay is 2 ms with select high, 100 ms with select low.
// R15: chip-select is sampled at the output-enable rising edge.
// R16: chip-select high at that edge enters idle with static outputs.
// R17: only a new power-up leaves that idle state.
// R18: an external party holding output-enable low extends reset.
// R19: host issues no scan or programming opcodes before power-on completes.
// R20: unknown opcodes select bypass and leave the init pin alone.
`timescale 1ns/10ps
`default_nettype none
module jcp_port
  import jcp_pkg::*;
#(
  parameter int POR_SHORT = POR_SHORT_CYC,
  parameter int POR_LONG  = POR_LONG_CYC
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_tck,
  input  wire logic                i_tms,
  input  wire logic                i_tdi,
  output logic                     o_tdo,
  output logic                     o_tdo_oe,
  input  wire logic                i_por_delay_select,
  input  wire logic                i_oe_line,
  output logic                     o_oe_line,
  output logic                     o_oe_line_oe,
  input  wire logic                i_chip_select_sense_n,
  output logic                     o_config_init_pin_n,
  output logic                     o_config_init_pin_oe,
  input  wire logic [BSR_LEN-1:0]  i_pin_levels,
  output logic [BSR_LEN-1:0]       o_pin_drive,
  output logic                     o_extest_active,
  input  wire logic [ID_LEN-1:0]   i_usercode,
  output logic                     o_config_enable,
  output logic                     o_config_idle
);
  logic [2:0] tck_s_r;
  logic [1:0] tms_s_r;
  logic [1:0] tdi_s_r;
  logic [1:0] psel_s_r;
  logic [1:0] oe_s_r;
  logic [1:0] cs_s_r;
  logic       tck_rise;
  logic       tck_fall;
  jcp_tap_type tap;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tck_s_r  <= 3'h0;
      tms_s_r  <= 2'h3;
      tdi_s_r  <= 2'h3;
      psel_s_r <= 2'h0;
      oe_s_r   <= 2'h0;
      cs_s_r   <= 2'h3;
    end else begin
      tck_s_r  <= {tck_s_r[1:0], i_tck};
      tms_s_r  <= {tms_s_r[0], i_tms};
      tdi_s_r  <= {tdi_s_r[0], i_tdi};
      psel_s_r <= {psel_s_r[0], i_por_delay_select};
      oe_s_r   <= {oe_s_r[0], i_oe_line};
      cs_s_r   <= {cs_s_r[0], i_chip_select_sense_n};
    end
  end

  assign tck_rise = tck_s_r[1] & ~tck_s_r[2];
  assign tck_fall = ~tck_s_r[1] & tck_s_r[2];

  jcp_tap_fsm u_tap (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_tck_rise (tck_rise),
    .i_tms      (tms_s_r[1]),
    .o_state    (tap)
  );

  function automatic logic is_scan_op(input logic [IR_LEN-1:0] op);
    is_scan_op = (op == OP_SAMPLE) || (op == OP_EXTEST);
  endfunction

  logic [IR_LEN-1:0]  ir_sh_r;
  logic [IR_LEN-1:0]  ir_r;
  logic [BSR_LEN-1:0] bsr_sh_r;
  logic [BSR_LEN-1:0] bsr_upd_r;
  logic [ID_LEN-1:0]  id_sh_r;
  logic               byp_r;
  logic               tdo_nxt;

  always_ff @(posedge i_clk) begin
    if (i_rst)
      ir_sh_r <= OP_BYPASS;
    else if (tck_rise && tap == TAP_CAP_IR)
      ir_sh_r <= {{(IR_LEN-2){1'b0}}, IR_CAPTURE};
    else if (tck_rise && tap == TAP_SH_IR)
      ir_sh_r <= {tdi_s_r[1], ir_sh_r[IR_LEN-1:1]}; // [R1]
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || tap == TAP_RESET)
      ir_r <= OP_IDCODE;
    else if (tck_fall && tap == TAP_UPD_IR)
      ir_r <= ir_sh_r; // [R1]
  end

  always_ff @(posedge i_clk) begin
    if (i_rst)
      bsr_sh_r <= '0;
    else if (tck_rise && is_scan_op(ir_r)) begin
      if (tap == TAP_CAP_DR)
        bsr_sh_r <= i_pin_levels; // [R3] [R4]
      else if (tap == TAP_SH_DR)
        bsr_sh_r <= {tdi_s_r[1], bsr_sh_r[BSR_LEN-1:1]}; // [R2]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst)
      bsr_upd_r <= '0;
    else if (tck_fall && tap == TAP_UPD_DR && is_scan_op(ir_r))
      bsr_upd_r <= bsr_sh_r; // [R3]
  end

  always_ff @(posedge i_clk) begin
    if (i_rst)
      id_sh_r <= '0;
    else if (tck_rise && tap == TAP_CAP_DR) begin
      if (ir_r == OP_IDCODE)
        id_sh_r <= ID_VALUE; // [R6]
      else if (ir_r == OP_USERCODE)
        id_sh_r <= i_usercode; // [R7]
    end else if (tck_rise && tap == TAP_SH_DR)
      id_sh_r <= {tdi_s_r[1], id_sh_r[ID_LEN-1:1]};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst)
      byp_r <= 1'b0;
    else if (tck_rise && tap == TAP_CAP_DR)
      byp_r <= 1'b0;
    else if (tck_rise && tap == TAP_SH_DR)
      byp_r <= tdi_s_r[1]; // [R5]
  end

  always_comb begin
    if (tap == TAP_SH_IR)
      tdo_nxt = ir_sh_r[0];
    else if (is_scan_op(ir_r))
      tdo_nxt = bsr_sh_r[0]; // [R2]
    else if (ir_r == OP_IDCODE || ir_r == OP_USERCODE)
      tdo_nxt = id_sh_r[0]; // [R6] [R7]
    else
      tdo_nxt = byp_r; // [R5] [R20]
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tdo    <= 1'b1;
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      o_tdo    <= tdo_nxt;
      o_tdo_oe <= (tap == TAP_SH_IR) || (tap == TAP_SH_DR);
    end
  end

  assign o_pin_drive     = bsr_upd_r;
  assign o_extest_active = (ir_r == OP_EXTEST); // [R4]

  // init pin control
  logic hold_r;
  logic pulse_r;

  always_ff @(posedge i_clk) begin
    if (i_rst)
      hold_r <= 1'b0;
    else if (ir_r == OP_HOLD_CFG)
      hold_r <= 1'b1; // [R10]
    else if (ir_r == OP_START_CFG && tap == TAP_IDLE)
      hold_r <= 1'b0; // [R11]
  end

  always_ff @(posedge i_clk) begin
    if (i_rst)
      pulse_r <= 1'b0;
    else
      pulse_r <= (ir_r == OP_START_CFG) && (tap == TAP_IDLE); // [R8] [R9]
  end

  assign o_config_init_pin_n  = 1'b0;
  assign o_config_init_pin_oe = hold_r | pulse_r; // [R8] [R9] [R11] [R20]

  // power-up sequencing
  jcp_pwr_type          pwr_r;
  logic [POR_CNT_W-1:0] por_cnt_r;
  logic [POR_CNT_W-1:0] por_lim;
  logic                 oe_prev_r;

  assign por_lim = psel_s_r[1] ? POR_CNT_W'(POR_SHORT - 1)
                               : POR_CNT_W'(POR_LONG - 1); // [R14]

  always_ff @(posedge i_clk) begin
    if (i_rst)
      por_cnt_r <= '0;
    else if (pwr_r == PWR_POR && por_cnt_r != por_lim)
      por_cnt_r <= por_cnt_r + 1'b1;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst)
      oe_prev_r <= 1'b0;
    else
      oe_prev_r <= oe_s_r[1];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst)
      pwr_r <= PWR_POR;
    else begin
      case (pwr_r)
        PWR_POR:
          if (por_cnt_r == por_lim)
            pwr_r <= PWR_WAIT; // [R13]
        PWR_WAIT:
          if (oe_s_r[1] && !oe_prev_r) begin // [R15] [R18]
            if (cs_s_r[1])
              pwr_r <= PWR_IDLE; // [R16]
            else
              pwr_r <= PWR_RUN;
          end
        PWR_RUN:
          if (!oe_s_r[1])
            pwr_r <= PWR_WAIT; // [R18]
        PWR_IDLE:
          pwr_r <= PWR_IDLE; // [R17]
        default:
          pwr_r <= PWR_POR;
      endcase
    end
  end

  assign o_oe_line       = 1'b0;
  assign o_oe_line_oe    = (pwr_r == PWR_POR); // [R13]
  assign o_config_enable = (pwr_r == PWR_RUN); // [R16]
  assign o_config_idle   = (pwr_r == PWR_IDLE);
endmodule
`default_nettype wire

// ===== verilog/jcp_tap_fsm.sv
`timescale 1ns/10ps
`default_nettype none
module jcp_tap_fsm
  import jcp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_tck_rise,
  input  wire logic        i_tms,
  output var  jcp_tap_type o_state
);
  jcp_tap_type state_r;
  jcp_tap_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TAP_RESET:  state_nxt = i_tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   state_nxt = i_tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: state_nxt = i_tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: state_nxt = i_tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  state_nxt = i_tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: state_nxt = i_tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: state_nxt = i_tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: state_nxt = i_tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: state_nxt = i_tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: state_nxt = i_tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: state_nxt = i_tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  state_nxt = i_tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: state_nxt = i_tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: state_nxt = i_tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: state_nxt = i_tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: state_nxt = i_tms ? TAP_SEL_DR : TAP_IDLE;
      default:    state_nxt = TAP_RESET;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst)
      state_r <= TAP_RESET;
    else if (i_tck_rise)
      state_r <= state_nxt;
  end

  assign o_state = state_r;
endmodule
`default_nettype wire
